// File: pkg/uhpet_params.svh
`ifndef UHPET_PARAMS_SVH
`define UHPET_PARAMS_SVH
// clock rate and microsecond tick
`define UHPET_CLK_MHZ 200
`define UHPET_US_CYC (`UHPET_CLK_MHZ)
`define UHPET_TW 15
// durations in microseconds, counted as ticks
`define UHPET_T_DRST_US 15000
`define UHPET_T_DRSM_US 21000
`define UHPET_T_WTDCH_US 50
`define UHPET_T_DCHBIT_US 50
`define UHPET_T_DCHSE0_US 300
`define UHPET_T_WTRSM_US 5000
`define UHPET_T_DRSMUP_US 10000
`define UHPET_T_WTREV_US 3060
`define UHPET_T_WTRSTHS_US 200
`define UHPET_T_UCH_US 2000
`define UHPET_T_WTFS_US 2000
`define UHPET_T_OC_US 550
// short filters in nanoseconds, counted as cycles
`define UHPET_T_FILT_NS 2500
`define UHPET_FILT_CYC ((`UHPET_T_FILT_NS * `UHPET_CLK_MHZ + 999) / 1000)
`define UHPET_T_LONG_NS 3000
`define UHPET_LONG_CYC ((`UHPET_T_LONG_NS * `UHPET_CLK_MHZ) / 1000)
// bit-time limits; full speed 12 Mbps, high speed 480 Mbps
`define UHPET_SE0RPT_BITS 23
`define UHPET_SE0RPT_CYC ((`UHPET_SE0RPT_BITS * `UHPET_CLK_MHZ) / 12)
`define UHPET_IPD_SD_BITS 88
`define UHPET_IPD_SD_CYC ((`UHPET_IPD_SD_BITS * `UHPET_CLK_MHZ + 479) / 480)
`define UHPET_IPD_OD_BITS 8
`define UHPET_IPD_OD_CYC ((`UHPET_IPD_OD_BITS * `UHPET_CLK_MHZ + 479) / 480)
`define UHPET_RSP_BITS 192
`define UHPET_RSP_CYC ((`UHPET_RSP_BITS * `UHPET_CLK_MHZ) / 480)
`endif

// File: pkg/uhpet_pkg.sv
`default_nettype none
package uhpet_pkg;
  `include "uhpet_params.svh"
  typedef logic [`UHPET_TW-1:0] uhpet_tick_type;
  typedef enum logic [2:0] {DS_IDLE, DS_RST, DS_WTCH, DS_CHK, DS_CHJ, DS_RSTEND, DS_RSM} uhpet_ds_type;
  typedef enum logic [2:0] {US_FS, US_HS, US_REV, US_WTHS, US_CHIRP, US_WTHOST, US_RSMUP} uhpet_us_type;
endpackage
`default_nettype wire

// File: pkg/uhpet_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface uhpet_tmr_if;
  import uhpet_pkg::*;
  logic           start;
  logic           stop;
  uhpet_tick_type len;
  uhpet_tick_type cnt;
  logic           busy;
  logic           done;
  modport ctl (output start, stop, len, input cnt, busy, done);
  modport tmr (input start, stop, len, output cnt, busy, done);
endinterface
`default_nettype wire

// File: hw/uhpet_timer.sv
`timescale 1ns/10ps
`default_nettype none
module uhpet_timer
  import uhpet_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic tick,
  uhpet_tmr_if.tmr  t
);
  uhpet_tick_type cnt_r;
  logic           busy_r;
  logic           done_r;

  // one-shot down counter; done pulses one cycle at expiry
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (t.start)
      begin
        cnt_r  <= t.len;
        busy_r <= 1'b1;
      end
      else if (t.stop)
      begin
        cnt_r  <= '0;
        busy_r <= 1'b0;
      end
      else if (busy_r && tick)
      begin
        if (cnt_r <= uhpet_tick_type'(1))
        begin
          cnt_r  <= '0;
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r - uhpet_tick_type'(1);
      end
    end
  end

  assign t.cnt  = cnt_r;
  assign t.busy = busy_r;
  assign t.done = done_r;
endmodule
`default_nettype wire

// File: hw/uhpet_filt.sv
`timescale 1ns/10ps
`default_nettype none
module uhpet_filt #(
  parameter int unsigned THR = 1
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic en,
  input  wire logic lvl,
  output var  logic out
);
  localparam logic [16:0] THR_W = 17'(THR);
  logic [16:0] cnt_r;
  logic        out_r;

  // level must hold for THR enables without a break
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r <= 17'h0;
      out_r <= 1'b0;
    end
    else
    begin
      if (!lvl)
        cnt_r <= 17'h0;
      else if (en && cnt_r != THR_W)
        cnt_r <= cnt_r + 17'h1;
      out_r <= lvl && (cnt_r == THR_W);
    end
  end

  assign out = out_r;
endmodule
`default_nettype wire

// File: hw/uhpet_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "uhpet_params.svh"
// What this block does
// - port reset drives SE0 10 to 20 ms
// - controlling hub drives downstream resume 20+ ms
// - rebroadcast sensed downstream resume within 1 ms
// - long upstream K recognised within 2.5-100 us
// - long upstream SE0 recognised within 2.5-10000 us
// - repeated SE0 upstream capped at 23 bits
// - high-speed packet gaps 88 same, 8 opposite
// - response starts within 192 bit times; the block only flags rsp_late when a response is still pending then
// - chirps valid after 2.5 us unbroken
// - hub chirp starts within 100 us
// - each downstream chirp lasts 40-60 us
// - chirps end 100-500 us before reset end
// - remote wakeup needs 5 ms idle bus
// - upstream resume lasts 1 to 15 ms
// - suspended hub needs 2.5 us SE0 first
// - full-speed hub starts handshake within window
// - high-speed hub reverts after 3.0-3.125 ms
// - wait after revert before sampling bus
// - upstream chirp K 2 ms, done by 7
// - host chirp seen, enter high speed quickly
// - no host chirp, back to full speed
// - overcurrent cuts power 500 to 625 us
// - overcurrent only counts while power on
module uhpet_core
  import uhpet_pkg::*;
#(
  parameter uhpet_tick_type P_DRST   = uhpet_tick_type'(`UHPET_T_DRST_US),
  parameter uhpet_tick_type P_DRSM   = uhpet_tick_type'(`UHPET_T_DRSM_US),
  parameter uhpet_tick_type P_WTDCH  = uhpet_tick_type'(`UHPET_T_WTDCH_US),
  parameter uhpet_tick_type P_DCHBIT = uhpet_tick_type'(`UHPET_T_DCHBIT_US),
  parameter uhpet_tick_type P_DCHSE0 = uhpet_tick_type'(`UHPET_T_DCHSE0_US),
  parameter uhpet_tick_type P_WTRSM  = uhpet_tick_type'(`UHPET_T_WTRSM_US),
  parameter uhpet_tick_type P_DRSMUP = uhpet_tick_type'(`UHPET_T_DRSMUP_US),
  parameter uhpet_tick_type P_WTREV  = uhpet_tick_type'(`UHPET_T_WTREV_US),
  parameter uhpet_tick_type P_WTHS   = uhpet_tick_type'(`UHPET_T_WTRSTHS_US),
  parameter uhpet_tick_type P_UCH    = uhpet_tick_type'(`UHPET_T_UCH_US),
  parameter uhpet_tick_type P_WTFS   = uhpet_tick_type'(`UHPET_T_WTFS_US),
  parameter uhpet_tick_type P_OC     = uhpet_tick_type'(`UHPET_T_OC_US)
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ds_reset_req,
  input  wire logic ds_resume_req,
  input  wire logic ds_suspended,
  input  wire logic ds_k_in,
  output var  logic ds_se0_drive,
  output var  logic ds_chirp_k_drive,
  output var  logic ds_chirp_j_drive,
  output var  logic ds_resume_drive,
  output var  logic ds_hs_port,
  input  wire logic us_se0_in,
  input  wire logic us_k_in,
  input  wire logic us_j_in,
  input  wire logic remote_wake_req,
  output var  logic us_chirp_k_drive,
  output var  logic us_resume_drive,
  output var  logic us_hs_mode,
  output var  logic us_long_k,
  output var  logic us_long_se0,
  input  wire logic rpt_se0_in,
  output var  logic rpt_se0_out,
  input  wire logic pkt_end,
  input  wire logic pkt_up,
  input  wire logic tx_req,
  input  wire logic tx_up,
  input  wire logic tx_rsp,
  output var  logic tx_grant,
  output var  logic rsp_late,
  input  wire logic port_power_on,
  input  wire logic overcurrent_sense_n,
  output var  logic port_power_ctrl_n,
  output var  logic oc_tripped
);
  localparam logic [7:0]  DIV_LAST = 8'(`UHPET_US_CYC - 1);
  localparam logic [8:0]  RPT_LIM  = 9'(`UHPET_SE0RPT_CYC);
  localparam logic [7:0]  SD_CYC   = 8'(`UHPET_IPD_SD_CYC);
  localparam logic [7:0]  OD_CYC   = 8'(`UHPET_IPD_OD_CYC);
  localparam logic [7:0]  RSP_CYC  = 8'(`UHPET_RSP_CYC);
  localparam logic [9:0]  FILT_W   = 10'(`UHPET_FILT_CYC);

  logic [7:0]     div_r;
  logic           tick_r;
  logic [4:0]     sy1_r;
  logic [4:0]     sy2_r;
  uhpet_ds_type   ds_r;
  uhpet_ds_type   ds_nxt;
  uhpet_us_type   us_r;
  uhpet_us_type   us_nxt;
  logic           dch_seen_r;
  logic           ds_hs_r;
  logic           dsk_d_r;
  logic           host_k_r;
  logic           us_hs_r;
  logic           lse0_d_r;
  logic           wake_pend_r;
  uhpet_tick_type idle_r;
  logic [8:0]     rpt_cnt_r;
  logic           rpt_out_r;
  logic [7:0]     gap_r;
  logic           last_up_r;
  logic           rsp_late_r;
  logic           oc_trip_r;
  logic           pwr_n_r;

  uhpet_tmr_if td ();
  uhpet_tmr_if tc ();
  uhpet_tmr_if tu ();

  // microsecond tick enable
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == DIV_LAST);
      div_r  <= (div_r == DIV_LAST) ? 8'h00 : div_r + 8'h01;
    end
  end

  // two-stage synchronisers for pin inputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sy1_r <= 5'h10;
      sy2_r <= 5'h10;
    end
    else
    begin
      sy1_r <= {overcurrent_sense_n, us_j_in, us_k_in, us_se0_in, ds_k_in};
      sy2_r <= sy1_r;
    end
  end

  wire ds_k_s  = sy2_r[0];
  wire us_se0_s = sy2_r[1];
  wire us_k_s  = sy2_r[2];
  wire us_j_s  = sy2_r[3];
  wire oc_n_s  = sy2_r[4];

  // line filters; long K and long SE0 flags
  wire ds_k_f;
  wire us_k_f;
  wire us_j_f;
  wire oc_f;
  wire oc_lvl = !oc_n_s && !pwr_n_r;
  uhpet_filt #(.THR(`UHPET_FILT_CYC)) f_dsk (.clock(clock), .rst_n(rst_n), .en(1'b1), .lvl(ds_k_s), .out(ds_k_f));
  uhpet_filt #(.THR(`UHPET_FILT_CYC)) f_usk (.clock(clock), .rst_n(rst_n), .en(1'b1), .lvl(us_k_s), .out(us_k_f));
  uhpet_filt #(.THR(`UHPET_FILT_CYC)) f_usj (.clock(clock), .rst_n(rst_n), .en(1'b1), .lvl(us_j_s), .out(us_j_f));
  uhpet_filt #(.THR(`UHPET_LONG_CYC)) f_lk (.clock(clock), .rst_n(rst_n), .en(1'b1), .lvl(us_k_s), .out(us_long_k));
  uhpet_filt #(.THR(`UHPET_LONG_CYC)) f_ls (.clock(clock), .rst_n(rst_n), .en(1'b1), .lvl(us_se0_s), .out(us_long_se0));
  uhpet_filt #(.THR(P_OC)) f_oc (.clock(clock), .rst_n(rst_n), .en(tick_r), .lvl(oc_lvl), .out(oc_f));

  uhpet_timer u_td (.clock(clock), .rst_n(rst_n), .tick(tick_r), .t(td));
  uhpet_timer u_tc (.clock(clock), .rst_n(rst_n), .tick(tick_r), .t(tc));
  uhpet_timer u_tu (.clock(clock), .rst_n(rst_n), .tick(tick_r), .t(tu));

  // decodes feeding the sequencers and the checks
  wire uhpet_tick_type room_lim = uhpet_tick_type'(P_DCHSE0 + P_DCHBIT);
  wire room        = (td.cnt >= room_lim);
  wire idle_ok     = (idle_r == P_WTRSM);
  wire lse0_rise   = us_long_se0 && !lse0_d_r;
  wire ds_rsm_sense = ds_k_f && !dsk_d_r && ds_suspended && (ds_r == DS_IDLE);
  wire rsm_go      = (wake_pend_r && idle_ok) || ds_rsm_sense;
  wire ds_rst_act  = (ds_r != DS_IDLE) && (ds_r != DS_RSM);

  // downstream reset, chirp and resume sequencer
  always_comb
  begin
    ds_nxt   = ds_r;
    td.start = 1'b0;
    td.stop  = 1'b0;
    td.len   = P_DRST;
    tc.start = 1'b0;
    tc.stop  = 1'b0;
    tc.len   = P_WTDCH;
    case (ds_r)
      DS_IDLE:
        if (ds_reset_req)
        begin
          ds_nxt   = DS_RST;
          td.start = 1'b1;
        end
        else if (ds_resume_req)
        begin
          ds_nxt   = DS_RSM;
          td.start = 1'b1;
          td.len   = P_DRSM;
        end
      DS_RST:
        if (td.done)
          ds_nxt = DS_IDLE;
        else if (dch_seen_r && !ds_k_s && room)
        begin
          ds_nxt   = DS_WTCH;
          tc.start = 1'b1;
        end
      DS_WTCH, DS_CHK, DS_CHJ:
        if (td.done)
        begin
          ds_nxt  = DS_IDLE;
          tc.stop = 1'b1;
        end
        else if (tc.done)
        begin
          if (!room)
            ds_nxt = DS_RSTEND;
          else
          begin
            ds_nxt   = (ds_r == DS_CHK) ? DS_CHJ : DS_CHK;
            tc.start = 1'b1;
            tc.len   = P_DCHBIT;
          end
        end
      DS_RSTEND, DS_RSM:
        if (td.done)
          ds_nxt = DS_IDLE;
      default:
        ds_nxt = DS_IDLE;
    endcase
  end

  // upstream speed detection and resume sequencer
  always_comb
  begin
    us_nxt   = us_r;
    tu.start = 1'b0;
    tu.stop  = 1'b0;
    tu.len   = P_UCH;
    case (us_r)
      US_FS, US_HS:
        if (rsm_go)
        begin
          us_nxt   = US_RSMUP;
          tu.start = 1'b1;
          tu.len   = P_DRSMUP;
        end
        else if (us_r == US_FS && lse0_rise)
        begin
          us_nxt   = US_CHIRP;
          tu.start = 1'b1;
        end
        else if (us_r == US_HS && us_se0_s)
        begin
          us_nxt   = US_REV;
          tu.start = 1'b1;
          tu.len   = P_WTREV;
        end
      US_REV:
        if (!us_se0_s)
        begin
          us_nxt  = US_HS;
          tu.stop = 1'b1;
        end
        else if (tu.done)
        begin
          us_nxt   = US_WTHS;
          tu.start = 1'b1;
          tu.len   = P_WTHS;
        end
      US_WTHS:
        if (tu.done)
        begin
          us_nxt   = us_se0_s ? US_CHIRP : US_FS;
          tu.start = us_se0_s;
        end
      US_CHIRP:
        if (tu.done)
        begin
          us_nxt   = US_WTHOST;
          tu.start = 1'b1;
          tu.len   = P_WTFS;
        end
      US_WTHOST:
        if (host_k_r && us_j_f)
        begin
          us_nxt  = US_HS;
          tu.stop = 1'b1;
        end
        else if (tu.done)
          us_nxt = US_FS;
      US_RSMUP:
        if (tu.done)
          us_nxt = us_hs_r ? US_HS : US_FS;
      default:
        us_nxt = US_FS;
    endcase
  end

  // state registers and chirp tracking
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ds_r       <= DS_IDLE;
      us_r       <= US_FS;
      dch_seen_r <= 1'b0;
      ds_hs_r    <= 1'b0;
      dsk_d_r    <= 1'b0;
      host_k_r   <= 1'b0;
      us_hs_r    <= 1'b0;
      lse0_d_r   <= 1'b0;
    end
    else
    begin
      ds_r       <= ds_nxt;
      us_r       <= us_nxt;
      dch_seen_r <= (ds_r == DS_RST) && (dch_seen_r || ds_k_f);
      dsk_d_r    <= ds_k_f;
      host_k_r   <= (us_r == US_WTHOST) && (host_k_r || us_k_f);
      lse0_d_r   <= us_long_se0;
      if (ds_r == DS_IDLE && ds_reset_req)
        ds_hs_r <= 1'b0;
      else if (ds_nxt == DS_CHK)
        ds_hs_r <= 1'b1;
      if (us_nxt == US_HS)
        us_hs_r <= 1'b1;
      else if (us_nxt == US_FS || us_nxt == US_WTHS)
        us_hs_r <= 1'b0;
    end
  end

  // idle time and pending remote wakeup; a new request beats the clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      idle_r      <= '0;
      wake_pend_r <= 1'b0;
    end
    else
    begin
      if (!us_j_s || us_se0_s)
        idle_r <= '0;
      else if (tick_r && !idle_ok)
        idle_r <= idle_r + uhpet_tick_type'(1);
      wake_pend_r <= remote_wake_req || (wake_pend_r && !(us_nxt == US_RSMUP && us_r != US_RSMUP));
    end
  end

  // repeated SE0 cap and high-speed gap tracking
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rpt_cnt_r  <= 9'h000;
      rpt_out_r  <= 1'b0;
      gap_r      <= 8'hFF;
      last_up_r  <= 1'b0;
      rsp_late_r <= 1'b0;
    end
    else
    begin
      rpt_cnt_r  <= !rpt_se0_in ? 9'h000 : (rpt_cnt_r == RPT_LIM) ? rpt_cnt_r : rpt_cnt_r + 9'h001;
      rpt_out_r  <= rpt_se0_in && (rpt_cnt_r < RPT_LIM);
      gap_r      <= pkt_end ? 8'h00 : (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
      last_up_r  <= pkt_end ? pkt_up : last_up_r;
      rsp_late_r <= tx_req && tx_rsp && (gap_r == RSP_CYC);
    end
  end

  // overcurrent latch holds until power is withdrawn; a new trip wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      oc_trip_r <= 1'b0;
      pwr_n_r   <= 1'b1;
    end
    else
    begin
      oc_trip_r <= oc_f || (oc_trip_r && port_power_on);
      pwr_n_r   <= !(port_power_on && !oc_f && !oc_trip_r);
    end
  end

  // output decode
  assign tx_grant          = !pkt_end && (gap_r >= ((tx_up == last_up_r) ? SD_CYC : OD_CYC));
  assign ds_se0_drive      = (ds_r == DS_RST) || (ds_r == DS_WTCH) || (ds_r == DS_RSTEND);
  assign ds_chirp_k_drive  = (ds_r == DS_CHK);
  assign ds_chirp_j_drive  = (ds_r == DS_CHJ);
  assign ds_resume_drive   = (ds_r == DS_RSM);
  assign ds_hs_port        = ds_hs_r;
  assign us_chirp_k_drive  = (us_r == US_CHIRP);
  assign us_resume_drive   = (us_r == US_RSMUP);
  assign us_hs_mode        = us_hs_r;
  assign rpt_se0_out       = rpt_out_r;
  assign rsp_late          = rsp_late_r;
  assign port_power_ctrl_n = pwr_n_r;
  assign oc_tripped        = oc_trip_r;

  // checking helpers: elapsed ticks since downstream left idle and per upstream state, run lengths
  uhpet_tick_type h_ds_r;
  uhpet_tick_type h_us_r;
  logic [9:0]     h_krun_r;
  logic [9:0]     h_srun_r;
  logic [9:0]     h_orun_r;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      h_ds_r   <= '0;
      h_us_r   <= '0;
      h_krun_r <= 10'h000;
      h_srun_r <= 10'h000;
      h_orun_r <= 10'h000;
    end
    else
    begin
      h_ds_r   <= (ds_r == DS_IDLE) ? '0 : h_ds_r + uhpet_tick_type'(tick_r);
      h_us_r   <= (us_nxt != us_r) ? '0 : h_us_r + uhpet_tick_type'(tick_r);
      h_krun_r <= !us_k_s ? 10'h000 : (&h_krun_r) ? h_krun_r : h_krun_r + 10'h001;
      h_srun_r <= !us_se0_s ? 10'h000 : (&h_srun_r) ? h_srun_r : h_srun_r + 10'h001;
      h_orun_r <= !rpt_out_r ? 10'h000 : (&h_orun_r) ? h_orun_r : h_orun_r + 10'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_DS_RST_LEN: assert property (ds_rst_act && ds_nxt == DS_IDLE |-> h_ds_r == P_DRST)
    else $error("downstream reset length wrong");
  AST_DS_RSM_LEN: assert property (ds_r == DS_RSM && ds_nxt == DS_IDLE |-> h_ds_r == P_DRSM)
    else $error("downstream resume length wrong");
  AST_RSM_REBC: assert property (ds_rsm_sense && us_r == US_FS |=> us_resume_drive)
    else $error("downstream resume not rebroadcast");
  AST_LONG_K: assert property ($rose(us_long_k) |-> h_krun_r >= FILT_W)
    else $error("long K flagged too early");
  AST_LONG_SE0: assert property ($rose(us_long_se0) |-> h_srun_r >= FILT_W)
    else $error("long SE0 flagged too early");
  AST_SE0_CAP: assert property (h_orun_r <= 10'(RPT_LIM))
    else $error("repeated SE0 too long");
  AST_IPD_SD: assert property (tx_req && tx_grant && tx_up == last_up_r |-> gap_r >= SD_CYC)
    else $error("same-direction gap too short");
  AST_RSP_LATE: assert property (tx_req && tx_rsp && gap_r == RSP_CYC |=> rsp_late)
    else $error("late response not flagged");
  AST_UCH_LEN: assert property (us_r == US_CHIRP && us_nxt != US_CHIRP |-> h_us_r == P_UCH)
    else $error("upstream chirp length wrong");
  AST_WTFS_LEN: assert property (us_r == US_WTHOST && us_nxt == US_FS |-> h_us_r == P_WTFS)
    else $error("full-speed fallback time wrong");
endmodule
`default_nettype wire

// File: tb/uhpet_peer.sv
`timescale 1ns/10ps
`default_nettype none
module uhpet_peer
(
  input  wire logic clock,
  input  wire logic us_chirp_k_drive,
  input  wire logic dev_go,
  input  wire logic host_ans,
  input  wire logic bus_idle,
  output var  logic ds_k_in,
  output var  logic us_k_in,
  output var  logic us_j_in
);
  logic hj;
  // idle j upstream only while the host is not driving k
  assign us_j_in = hj | (bus_idle & ~us_k_in);
  // device: one k of 5 us, 5 us after the command (reset chirp or resume)
  initial
  begin
    ds_k_in = 1'b0;
    forever
    begin
      wait (dev_go === 1'b1);
      repeat (1000) @(posedge clock);
      #1 ds_k_in = 1'b1;
      repeat (1000) @(posedge clock);
      #1 ds_k_in = 1'b0;
      wait (dev_go !== 1'b1);
    end
  end
  // host: answers the hub chirp with k then j, each held 5 us
  initial
  begin
    us_k_in = 1'b0;
    hj = 1'b0;
    forever
    begin
      @(negedge us_chirp_k_drive);
      if (host_ans === 1'b1)
      begin
        repeat (100) @(posedge clock);
        #1 us_k_in = 1'b1;
        repeat (1000) @(posedge clock);
        #1 us_k_in = 1'b0;
        hj = 1'b1;
        repeat (1000) @(posedge clock);
        #1 hj = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int US = 200;
  localparam int DRST = 40, DRSM = 30, WTDCH = 2, DCHBIT = 3, DCHSE0 = 6, WTRSM = 10, DRSMUP = 8;
  localparam int WTREV = 6, WTHS = 3, UCH = 5, WTFS = 10, OC = 4;
  localparam int LATE = 10, HS = 9, LK = 8, LSE0 = 7, UCK = 6, URS = 5, DRS = 4, RPT = 3, GNT = 2, PWR = 1;
  logic clock, rst_n, ds_reset_req, ds_resume_req, ds_suspended, ds_k_in, ds_se0_drive;
  logic ds_chirp_k_drive, ds_chirp_j_drive, ds_resume_drive, ds_hs_port, us_se0_in, us_k_in;
  logic us_j_in, remote_wake_req, us_chirp_k_drive, us_resume_drive, us_hs_mode, us_long_k;
  logic us_long_se0, rpt_se0_in, rpt_se0_out, pkt_end, pkt_up, tx_req, tx_up, tx_grant;
  logic rsp_late, port_power_on, overcurrent_sense_n, port_power_ctrl_n, oc_tripped;
  logic dev_go, host_ans, bus_idle, tx_rsp;
  int   miscompares = 0;
  int   samples_checked = 0;
  wire logic [10:0] obs = {rsp_late, us_hs_mode, us_long_k, us_long_se0, us_chirp_k_drive, us_resume_drive,
                          ds_resume_drive, rpt_se0_out, tx_grant, port_power_ctrl_n, oc_tripped};
  uhpet_core #(.P_DRST(15'(DRST)), .P_DRSM(15'(DRSM)), .P_WTDCH(15'(WTDCH)), .P_DCHBIT(15'(DCHBIT)),
    .P_DCHSE0(15'(DCHSE0)), .P_WTRSM(15'(WTRSM)), .P_DRSMUP(15'(DRSMUP)), .P_WTREV(15'(WTREV)),
    .P_WTHS(15'(WTHS)), .P_UCH(15'(UCH)), .P_WTFS(15'(WTFS)), .P_OC(15'(OC))) dut_u (
    .clock(clock), .rst_n(rst_n), .ds_reset_req(ds_reset_req), .ds_resume_req(ds_resume_req),
    .ds_suspended(ds_suspended), .ds_k_in(ds_k_in), .ds_se0_drive(ds_se0_drive),
    .ds_chirp_k_drive(ds_chirp_k_drive), .ds_chirp_j_drive(ds_chirp_j_drive),
    .ds_resume_drive(ds_resume_drive), .ds_hs_port(ds_hs_port), .us_se0_in(us_se0_in),
    .us_k_in(us_k_in), .us_j_in(us_j_in), .remote_wake_req(remote_wake_req),
    .us_chirp_k_drive(us_chirp_k_drive), .us_resume_drive(us_resume_drive), .us_hs_mode(us_hs_mode),
    .us_long_k(us_long_k), .us_long_se0(us_long_se0), .rpt_se0_in(rpt_se0_in),
    .rpt_se0_out(rpt_se0_out), .pkt_end(pkt_end), .pkt_up(pkt_up), .tx_req(tx_req), .tx_up(tx_up),
    .tx_rsp(tx_rsp), .tx_grant(tx_grant), .rsp_late(rsp_late), .port_power_on(port_power_on),
    .overcurrent_sense_n(overcurrent_sense_n), .port_power_ctrl_n(port_power_ctrl_n),
    .oc_tripped(oc_tripped));
  uhpet_peer peer_u (.clock(clock), .us_chirp_k_drive(us_chirp_k_drive), .dev_go(dev_go),
    .host_ans(host_ans), .bus_idle(bus_idle), .ds_k_in(ds_k_in), .us_k_in(us_k_in), .us_j_in(us_j_in));
  // comparison and reporting helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic in_rng(input string what, input int v, input int lo, input int hi);
    chk(what, 32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wait_for(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (obs[i] !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // port reset with a device chirp: length, chirp start, chirp width, stop margin
  task automatic t_ds_reset();
    int k0, k1, last, tot;
    k0 = 0; k1 = 0; last = 0; tot = 0;
    ds_reset_req = 1'b1;
    dev_go = 1'b1;
    cyc(1);
    ds_reset_req = 1'b0;
    dev_go = 1'b0;
    chk("se0_next", ds_se0_drive, 1);
    for (int t = 1; t < DRST * US + 400; t++)
    begin
      cyc(1);
      if (ds_chirp_k_drive === 1'b1 && k0 == 0) k0 = t;
      if (ds_chirp_k_drive === 1'b0 && k0 != 0 && k1 == 0) k1 = t;
      if (ds_chirp_k_drive === 1'b1 || ds_chirp_j_drive === 1'b1) last = t;
      if (ds_se0_drive | ds_chirp_k_drive | ds_chirp_j_drive) tot++;
    end
    in_rng("reset_len", tot, (DRST - 1) * US, (DRST + 1) * US + 2);
    in_rng("chirp_start", k0 - 2000, 0, (WTDCH + 1) * US + 20);
    in_rng("chirp_width", k1 - k0, (DCHBIT - 1) * US, (DCHBIT + 1) * US);
    in_rng("stop_margin", tot - last, (DCHSE0 - 1) * US, (DCHSE0 + DCHBIT + 1) * US);
    chk("hs_port", ds_hs_port, 1);
  endtask
  // downstream resume from the controlling hub
  task automatic t_ds_resume();
    int n;
    ds_resume_req = 1'b1;
    cyc(1);
    ds_resume_req = 1'b0;
    wait_for(DRS, 1'b1, 4, n);
    wait_for(DRS, 1'b0, (DRSM + 2) * US, n);
    in_rng("dn_resume_len", n, (DRSM - 1) * US, (DRSM + 1) * US);
  endtask
  // repeated se0 is cut short; high speed gaps both ways
  task automatic t_rpt_gap();
    int n;
    rpt_se0_in = 1'b1;
    wait_for(RPT, 1'b1, 3, n);
    wait_for(RPT, 1'b0, 500, n);
    in_rng("se0_repeat", n, 378, 383);
    rpt_se0_in = 1'b0;
    for (int d = 0; d < 2; d++)
    begin
      pkt_up = 1'b1;
      pkt_end = 1'b1;
      tx_req = 1'b1;
      tx_up = d[0];
      #1;
      chk("grant_at_end", tx_grant, 0);
      cyc(1);
      pkt_end = 1'b0;
      wait_for(GNT, 1'b1, 60, n);
      in_rng("gap", n, d ? 36 : 3, d ? 38 : 5);
      tx_req = 1'b0;
      cyc(1);
    end
    // response request still standing 80 cycles after the packet end
    tx_rsp = 1'b1;
    tx_req = 1'b1;
    pkt_end = 1'b1;
    cyc(1);
    pkt_end = 1'b0;
    wait_for(LATE, 1'b1, 100, n);
    in_rng("rsp_late", n, 80, 82);
    tx_req = 1'b0;
    tx_rsp = 1'b0;
  endtask
  // overcurrent counted only from power on, then power cut
  task automatic t_oc();
    int n;
    port_power_on = 1'b0;
    overcurrent_sense_n = 1'b0;
    cyc(2 * OC * US);
    port_power_on = 1'b1;
    wait_for(PWR, 1'b0, 5, n);
    chk("power_on", port_power_ctrl_n, 0);
    wait_for(PWR, 1'b1, (OC + 2) * US, n);
    in_rng("oc_cut", n, (OC - 1) * US, (OC + 1) * US + 10);
    chk("oc_flag", oc_tripped, 1);
    port_power_on = 1'b0;
    overcurrent_sense_n = 1'b1;
    cyc(6);
    chk("oc_clear", oc_tripped, 0);
  endtask
  // remote wakeup after idle, then resume sensed downstream
  task automatic t_wake();
    int n;
    remote_wake_req = 1'b1;
    cyc(1);
    remote_wake_req = 1'b0;
    cyc(50);
    chk("no_wake_busy", us_resume_drive, 0);
    bus_idle = 1'b1;
    wait_for(URS, 1'b1, (WTRSM + 2) * US, n);
    in_rng("wake_idle", n, (WTRSM - 1) * US, (WTRSM + 1) * US + 10);
    wait_for(URS, 1'b0, (DRSMUP + 2) * US, n);
    in_rng("up_resume_len", n, (DRSMUP - 1) * US, (DRSMUP + 1) * US);
    ds_suspended = 1'b1;
    dev_go = 1'b1;
    cyc(1);
    dev_go = 1'b0;
    wait_for(URS, 1'b1, 1800, n);
    in_rng("rebroadcast", n, 1490, 1530);
    wait_for(URS, 1'b0, (DRSMUP + 2) * US, n);
    ds_suspended = 1'b0;
  endtask
  // upstream handshake to high speed, then revert with no answer
  task automatic t_us();
    int n;
    host_ans = 1'b1;
    us_se0_in = 1'b1;
    wait_for(LSE0, 1'b1, 700, n);
    in_rng("long_se0", n, 600, 615);
    wait_for(UCK, 1'b1, 10, n);
    chk("us_chirp", us_chirp_k_drive, 1);
    us_se0_in = 1'b0;
    wait_for(UCK, 1'b0, (UCH + 2) * US, n);
    in_rng("us_chirp_len", n, (UCH - 1) * US, (UCH + 1) * US);
    wait_for(LK, 1'b1, 800, n);
    in_rng("long_k", n, 700, 720);
    wait_for(HS, 1'b1, 2000, n);
    chk("hs_mode", us_hs_mode, 1);
    host_ans = 1'b0;
    us_se0_in = 1'b1;
    wait_for(HS, 1'b0, (WTREV + 2) * US, n);
    in_rng("revert", n, (WTREV - 1) * US, (WTREV + 1) * US);
    wait_for(UCK, 1'b1, (WTHS + 2) * US, n);
    in_rng("post_revert", n, (WTHS - 1) * US, (WTHS + 1) * US + 10);
    us_se0_in = 1'b0;
    wait_for(UCK, 1'b0, (UCH + 2) * US, n);
    cyc((WTFS + 2) * US);
    chk("no_answer_fs", us_hs_mode, 0);
  endtask
  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // hang guard, about twice the expected run
  initial
  begin
    repeat (70000) @(posedge clock);
    miscompares++;
    close_out();
  end
  // reset, then the scenarios in turn
  initial
  begin
    {rst_n, ds_reset_req, ds_resume_req, ds_suspended, us_se0_in, remote_wake_req} = 6'h00;
    {rpt_se0_in, pkt_end, pkt_up, tx_req, tx_up, port_power_on} = 6'h00;
    {dev_go, host_ans, bus_idle, tx_rsp} = 4'h0;
    overcurrent_sense_n = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    t_ds_reset();
    t_ds_resume();
    t_rpt_gap();
    t_oc();
    t_wake();
    t_us();
    close_out();
  end
endmodule
`default_nettype wire
